// ==== verilog/bbx_exec.sv ====
// Executor for bit, branch, call, complement, decrement and clear instructions
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - bit_clear_op clears chosen bit, flags untouched
// - bit_set_op sets chosen bit, flags untouched
// - skip_if_bit_low_op skips next when bit zero
// - skip_if_bit_high_op skips next when bit one
// - relative_jump_op adds signed 9-bit literal to PC+1
// - jump_by_accumulator_op adds unsigned accumulator to PC+1
// - literal call pushes PC+1, latch supplies bits 14:11
// - accumulator call pushes PC+1, latch supplies 14:8
// - watchdog_clear_op zeroes watchdog, prescaler, sets flags
// - invert_op complements to accumulator or register, zero flag
// - zero_register_op writes zero, sets zero flag
// - decrement_op subtracts one, routes result, zero flag
// - zero_accumulator_op clears accumulator, sets zero flag
module bbx_exec
   import bbx_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Instruction stream from fetch
   input wire logic i_valid,
   input wire logic [13:0] i_instr,
   // File register read port, same cycle
   input wire logic [7:0] i_file_rdata,
   // Core state held outside this block
   input wire logic [7:0] i_acc,
   input wire logic [6:0] i_pc_upper_latch,
   // File register write port
   output logic o_file_we,
   output logic [6:0] o_file_addr,
   output logic [7:0] o_file_wdata,
   // Accumulator write port
   output logic o_acc_we,
   output logic [7:0] o_acc_wdata,
   // Zero flag update
   output logic o_zero_we,
   output logic o_result_null_flag,
   // Program counter and return stack
   output logic [14:0] o_pc,
   output logic o_push,
   output logic [14:0] o_stack_top,
   output logic o_flush,
   // Watchdog clear and power flags
   output logic o_wdt_clear,
   output logic o_timeout_flag_n,
   output logic o_sleep_flag_n
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum {BBX_RUN, BBX_KILL} bbx_phase_type;

   typedef struct packed {
      bbx_phase_type phase;
      logic [14:0] pc;
      logic file_we;
      logic [6:0] file_addr;
      logic [7:0] file_wdata;
      logic acc_we;
      logic [7:0] acc_wdata;
      logic zero_we;
      logic zflag;
      logic push;
      logic [14:0] stack_top;
      logic flush;
      logic wdt_clear;
      logic to_n;
      logic pd_n;
   } bbx_state_type;

   bbx_state_type st_r;
   bbx_state_type st_nxt;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [14:0] pc_inc;
   logic [6:0] f_addr;
   logic [2:0] b_sel;
   logic tbit;
   logic [7:0] b_mask;
   logic [7:0] res;

   assign pc_inc = st_r.pc + BBX_PC_ONE;
   assign f_addr = i_instr[6:0];
   assign b_sel = i_instr[9:7];
   assign tbit = i_file_rdata[b_sel];
   // One-hot mask of the selected bit, shared by set and clear
   assign b_mask = BBX_ONE_BYTE << b_sel;

   // Next-state logic, one instruction per cycle
   always_comb begin
      st_nxt = st_r;
      res = BBX_ZERO_BYTE;
      st_nxt.file_we = 1'b0;
      st_nxt.acc_we = 1'b0;
      st_nxt.zero_we = 1'b0;
      st_nxt.push = 1'b0;
      st_nxt.flush = 1'b0;
      st_nxt.wdt_clear = 1'b0;
      st_nxt.file_addr = f_addr;
      case (st_r.phase)
         BBX_KILL: begin
            // Discarded slot: no writes, only the counter moves
            if (i_valid) begin
               st_nxt.pc = pc_inc;
               st_nxt.phase = BBX_RUN;
            end
         end
         BBX_RUN: begin
            if (i_valid) begin
               st_nxt.pc = pc_inc;
               if (i_instr[13:10] == BBX_OP_BITCLR) begin
                  st_nxt.file_wdata = i_file_rdata & ~b_mask;
                  st_nxt.file_we = 1'b1;
               end else if (i_instr[13:10] == BBX_OP_BITSET) begin
                  st_nxt.file_wdata = i_file_rdata | b_mask;
                  st_nxt.file_we = 1'b1;
               end else if (i_instr[13:10] == BBX_OP_SKIPLO) begin
                  if (!tbit) begin
                     st_nxt.phase = BBX_KILL;
                     st_nxt.flush = 1'b1;
                  end
               end else if (i_instr[13:10] == BBX_OP_SKIPHI) begin
                  if (tbit) begin
                     st_nxt.phase = BBX_KILL;
                     st_nxt.flush = 1'b1;
                  end
               end else if (i_instr[13:9] == BBX_OP_RJMP) begin
                  // Sign extension of the 9-bit literal
                  st_nxt.pc = pc_inc + {{6{i_instr[8]}}, i_instr[8:0]};
                  st_nxt.phase = BBX_KILL;
                  st_nxt.flush = 1'b1;
               end else if (i_instr == BBX_JW_WORD) begin
                  st_nxt.pc = pc_inc + {7'h00, i_acc};
                  st_nxt.phase = BBX_KILL;
                  st_nxt.flush = 1'b1;
               end else if (i_instr[13:11] == BBX_OP_CALL) begin
                  st_nxt.stack_top = pc_inc;
                  st_nxt.push = 1'b1;
                  st_nxt.pc = {i_pc_upper_latch[6:3], i_instr[10:0]};
                  st_nxt.phase = BBX_KILL;
                  st_nxt.flush = 1'b1;
               end else if (i_instr == BBX_CW_WORD) begin
                  st_nxt.stack_top = pc_inc;
                  st_nxt.push = 1'b1;
                  st_nxt.pc = {i_pc_upper_latch, i_acc};
                  st_nxt.phase = BBX_KILL;
                  st_nxt.flush = 1'b1;
               end else if (i_instr == BBX_WDT_WORD) begin
                  st_nxt.wdt_clear = 1'b1;
                  st_nxt.to_n = 1'b1;
                  st_nxt.pd_n = 1'b1;
               end else if (i_instr == BBX_ZW_WORD) begin
                  st_nxt.acc_wdata = BBX_ZERO_BYTE;
                  st_nxt.acc_we = 1'b1;
                  st_nxt.zero_we = 1'b1;
                  st_nxt.zflag = 1'b1;
               end else if (i_instr[13:7] == BBX_OP_ZREG) begin
                  st_nxt.file_wdata = BBX_ZERO_BYTE;
                  st_nxt.file_we = 1'b1;
                  st_nxt.zero_we = 1'b1;
                  st_nxt.zflag = 1'b1;
               end else if (i_instr[13:8] == BBX_OP_INV || i_instr[13:8] == BBX_OP_DEC) begin
                  // Shared routing by the destination bit
                  if (i_instr[13:8] == BBX_OP_INV) begin
                     res = i_file_rdata ^ BBX_ONES_BYTE;
                  end else begin
                     res = i_file_rdata - BBX_ONE_BYTE;
                  end
                  st_nxt.zero_we = 1'b1;
                  st_nxt.zflag = (res == BBX_ZERO_BYTE);
                  if (i_instr[BBX_DEST_BIT]) begin
                     st_nxt.file_wdata = res;
                     st_nxt.file_we = 1'b1;
                  end else begin
                     st_nxt.acc_wdata = res;
                     st_nxt.acc_we = 1'b1;
                  end
               end
            end
         end
         default: begin
            st_nxt.phase = BBX_RUN;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
         st_r.phase <= BBX_RUN;
         st_r.pc <= BBX_PC_RESET;
         st_r.to_n <= 1'b1;
         st_r.pd_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign o_file_we = st_r.file_we;
   assign o_file_addr = st_r.file_addr;
   assign o_file_wdata = st_r.file_wdata;
   assign o_acc_we = st_r.acc_we;
   assign o_acc_wdata = st_r.acc_wdata;
   assign o_zero_we = st_r.zero_we;
   assign o_result_null_flag = st_r.zflag;
   assign o_pc = st_r.pc;
   assign o_push = st_r.push;
   assign o_stack_top = st_r.stack_top;
   assign o_flush = st_r.flush;
   assign o_wdt_clear = st_r.wdt_clear;
   assign o_timeout_flag_n = st_r.to_n;
   assign o_sleep_flag_n = st_r.pd_n;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_clr_no_flag: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_BITCLR)
      |=> o_file_we && !o_zero_we && o_file_wdata[$past(b_sel)] == 1'b0)
      else $error("bit clear wrong");
   a_set_no_flag: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_BITSET)
      |=> o_file_we && !o_zero_we && o_file_wdata[$past(b_sel)] == 1'b1)
      else $error("bit set wrong");
   a_skip_low_kill: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_SKIPLO && !tbit)
      |=> o_flush ##1 !o_file_we && !o_acc_we)
      else $error("low skip not taken");
   a_skip_high_kill: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_SKIPHI && tbit)
      |=> o_flush ##1 !o_file_we && !o_push)
      else $error("high skip not taken");
   a_rel_target: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:9] == BBX_OP_RJMP)
      |=> o_pc == $past(pc_inc) + {{6{$past(i_instr[8])}}, $past(i_instr[8:0])})
      else $error("relative target wrong");
   a_accjump_target: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_JW_WORD)
      |=> o_pc == $past(pc_inc) + {7'h00, $past(i_acc)})
      else $error("accumulator jump wrong");
   a_call_push: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:11] == BBX_OP_CALL)
      |=> o_push && o_stack_top == $past(pc_inc) && o_pc[14:11] == $past(i_pc_upper_latch[6:3]))
      else $error("literal call wrong");
   a_subroutine_via_accumulator_op_target: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_CW_WORD)
      |=> o_push && o_pc == {$past(i_pc_upper_latch), $past(i_acc)})
      else $error("accumulator call wrong");
   a_wdt_flags: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_WDT_WORD)
      |=> o_wdt_clear && o_timeout_flag_n && o_sleep_flag_n)
      else $error("watchdog clear wrong");
   a_zero_acc: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_ZW_WORD)
      |=> o_acc_we && o_acc_wdata == 8'h00 && o_result_null_flag)
      else $error("accumulator clear wrong");
   a_zero_reg: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:7] == BBX_OP_ZREG)
      |=> o_file_we && o_file_wdata == 8'h00 && o_result_null_flag)
      else $error("register clear wrong");
   a_inv_route: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:8] == BBX_OP_INV && !i_instr[7])
      |=> o_acc_we && o_acc_wdata == ~$past(i_file_rdata) && !o_file_we)
      else $error("complement route wrong");
   a_dec_route: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:8] == BBX_OP_DEC && i_instr[7])
      |=> o_file_we && o_file_wdata == $past(i_file_rdata) - 8'h01
          && o_result_null_flag == ($past(i_file_rdata) == 8'h01))
      else $error("decrement wrong");
   a_flush_quiet: assert property (
      o_flush |=> !o_file_we && !o_acc_we && !o_push && !o_wdt_clear && !o_flush)
      else $error("flushed slot had effect");

   // Bit operations keep the other seven bits and the address
   a_clr_keep_rest: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_BITCLR)
      |=> (o_file_wdata & ~$past(b_mask)) == ($past(i_file_rdata) & ~$past(b_mask))
          && o_file_addr == $past(f_addr) && !o_acc_we)
      else $error("bit clear touched other bits");
   a_set_keep_rest: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_BITSET)
      |=> (o_file_wdata & ~$past(b_mask)) == ($past(i_file_rdata) & ~$past(b_mask))
          && o_file_addr == $past(f_addr) && !o_acc_we)
      else $error("bit set touched other bits");

   // A skip whose test fails must fall through to the next word
   a_skip_low_pass: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_SKIPLO && tbit)
      |=> !o_flush && o_pc == $past(pc_inc))
      else $error("low skip taken wrongly");
   a_skip_high_pass: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:10] == BBX_OP_SKIPHI && !tbit)
      |=> !o_flush && o_pc == $past(pc_inc))
      else $error("high skip taken wrongly");

   // Jumps change flow only: no push, no data writes
   a_rel_no_push: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:9] == BBX_OP_RJMP)
      |=> o_flush && !o_push && !o_file_we && !o_acc_we)
      else $error("relative jump side effect");
   a_accjump_no_push: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_JW_WORD)
      |=> o_flush && !o_push && !o_file_we && !o_acc_we)
      else $error("accumulator jump side effect");

   // Calls load the low target bits and discard the fetched word
   a_call_low_bits: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:11] == BBX_OP_CALL)
      |=> o_pc[10:0] == $past(i_instr[10:0]) && o_flush)
      else $error("literal call target wrong");
   a_subroutine_via_accumulator_op_return: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_CW_WORD)
      |=> o_stack_top == $past(pc_inc) && o_flush)
      else $error("accumulator call return wrong");

   // Watchdog clear writes nothing and keeps the flow
   a_wdt_quiet: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_WDT_WORD)
      |=> !o_file_we && !o_acc_we && !o_flush && o_pc == $past(pc_inc))
      else $error("watchdog clear side effect");

   // The other destination of complement and decrement
   a_inv_to_reg: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:8] == BBX_OP_INV && i_instr[7])
      |=> o_file_we && o_file_wdata == ~$past(i_file_rdata) && !o_acc_we
          && o_result_null_flag == ($past(i_file_rdata) == 8'hff))
      else $error("complement to register wrong");
   a_dec_to_acc: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:8] == BBX_OP_DEC && !i_instr[7])
      |=> o_acc_we && o_acc_wdata == $past(i_file_rdata) - 8'h01 && !o_file_we)
      else $error("decrement to accumulator wrong");

   // Clears set the zero flag and touch only their own target
   a_zero_acc_only: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr == BBX_ZW_WORD)
      |=> o_zero_we && !o_file_we && !o_flush)
      else $error("accumulator clear side effect");
   a_zero_reg_only: assert property (
      (st_r.phase == BBX_RUN && i_valid && i_instr[13:7] == BBX_OP_ZREG)
      |=> o_zero_we && !o_acc_we && o_file_addr == $past(f_addr))
      else $error("register clear side effect");

   // The discarded slot still moves the counter by one
   a_kill_step: assert property (
      (st_r.phase == BBX_KILL && i_valid)
      |=> o_pc == $past(pc_inc) && !o_zero_we && !o_flush)
      else $error("discarded slot counter wrong");

   c_skip: cover property (o_flush && !$past(o_push));
   c_call: cover property (o_push);
   c_dec_zero: cover property (o_zero_we && o_result_null_flag && o_file_we);
   c_wdt: cover property (o_wdt_clear);
   c_inv_acc: cover property (o_acc_we && o_zero_we && !o_result_null_flag);

endmodule : bbx_exec

`default_nettype wire

// ==== inc/bbx_pkg.sv ====
// Package of encodings, field positions and reset values for the executor
package bbx_pkg;
   // ------------------------------------------------------------
   // Opcode and field layout (14-bit instruction word)
   // ------------------------------------------------------------
   localparam int BBX_IW = 14;
   localparam int BBX_PCW = 15;
   localparam logic [13:0] BBX_NOP_WORD = 14'h0000;
   localparam logic [13:0] BBX_WDT_WORD = 14'h0064;
   localparam logic [13:0] BBX_JW_WORD = 14'h000b;
   localparam logic [13:0] BBX_CW_WORD = 14'h000a;
   localparam logic [13:0] BBX_ZW_WORD = 14'h0100;
   localparam logic [3:0] BBX_OP_BITCLR = 4'h4;
   localparam logic [3:0] BBX_OP_BITSET = 4'h5;
   localparam logic [3:0] BBX_OP_SKIPLO = 4'h6;
   localparam logic [3:0] BBX_OP_SKIPHI = 4'h7;
   localparam logic [4:0] BBX_OP_RJMP = 5'h19;
   localparam logic [2:0] BBX_OP_CALL = 3'h4;
   localparam logic [6:0] BBX_OP_ZREG = 7'h03;
   localparam logic [5:0] BBX_OP_DEC = 6'h03;
   localparam logic [5:0] BBX_OP_INV = 6'h09;
   localparam int BBX_DEST_BIT = 7;
   localparam logic [7:0] BBX_ZERO_BYTE = 8'h00;
   localparam logic [7:0] BBX_ONES_BYTE = 8'hff;
   localparam logic [7:0] BBX_ONE_BYTE = 8'h01;
   localparam logic [14:0] BBX_PC_ONE = 15'h0001;
   localparam logic [14:0] BBX_PC_RESET = 15'h0000;
endpackage : bbx_pkg

// ==== tb/tb_top.sv ====
// Self-checking testbench for the bit, branch and call executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bbx_pkg::*;
   // ------------------------------------------------------------
   // Signals, model state and expected results
   // ------------------------------------------------------------
   typedef struct packed {
      logic fwe; logic [6:0] fa; logic [7:0] fd; logic awe; logic [7:0] ad; logic zwe;
      logic z; logic [14:0] pc; logic psh; logic [14:0] stk; logic fls; logic wdc;
   } bbx_exp_type;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_valid = 1'b0;
   logic [13:0] i_instr = 14'h0000;
   logic [7:0] i_file_rdata = 8'h00;
   logic [7:0] i_acc = 8'h00;
   logic [6:0] i_pc_upper_latch = 7'h00;
   logic o_file_we, o_acc_we, o_zero_we, o_result_null_flag, o_push, o_flush;
   logic o_wdt_clear, o_timeout_flag_n, o_sleep_flag_n;
   logic [6:0] o_file_addr;
   logic [7:0] o_file_wdata, o_acc_wdata;
   logic [14:0] o_pc, o_stack_top;
   bbx_exp_type x;
   bbx_exp_type e = '0;
   logic chk_on = 1'b0;
   logic m_kill = 1'b0;
   int error_cnt = 0;
   int n_tests = 0;
   // Boundary operands; entries after a flow change are the discarded slot
   localparam logic [13:0] DIR [20] = '{{BBX_OP_BITSET, 3'h7, 7'h7f},
      {BBX_OP_BITCLR, 3'h7, 7'h7f}, {BBX_OP_SKIPLO, 3'h0, 7'h01}, {BBX_OP_ZREG, 7'h05},
      {BBX_OP_RJMP, 9'h100}, BBX_NOP_WORD, {BBX_OP_RJMP, 9'h0ff}, BBX_NOP_WORD,
      {BBX_OP_CALL, 11'h7ff}, BBX_NOP_WORD, {BBX_OP_SKIPHI, 3'h0, 7'h02},
      {BBX_OP_DEC, 8'h10}, {BBX_OP_DEC, 8'h10}, {BBX_OP_INV, 8'h91}, BBX_ZW_WORD,
      BBX_CW_WORD, BBX_NOP_WORD, BBX_WDT_WORD, {BBX_OP_ZREG, 7'h7f}, {BBX_OP_DEC, 8'h85}};
   localparam logic [7:0] DFD [20] = '{8'h00, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h55, 8'h00};
   // Core clock, 25 ns period
   always #12.5 i_clk = ~i_clk;

   bbx_exec bbx_exec_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
      .i_instr(i_instr), .i_file_rdata(i_file_rdata), .i_acc(i_acc),
      .i_pc_upper_latch(i_pc_upper_latch), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
      .o_file_wdata(o_file_wdata), .o_acc_we(o_acc_we), .o_acc_wdata(o_acc_wdata),
      .o_zero_we(o_zero_we), .o_result_null_flag(o_result_null_flag), .o_pc(o_pc),
      .o_push(o_push), .o_stack_top(o_stack_top), .o_flush(o_flush),
      .o_wdt_clear(o_wdt_clear), .o_timeout_flag_n(o_timeout_flag_n),
      .o_sleep_flag_n(o_sleep_flag_n));

   // ------------------------------------------------------------
   // Compare, verdict and stimulus helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   // Random instruction of the given kind
   function automatic logic [13:0] gen(input int unsigned k);
      logic [13:0] r;
      r = 14'($urandom);
      case (k)
         0: gen = {BBX_OP_BITCLR, r[9:0]};
         1: gen = {BBX_OP_BITSET, r[9:0]};
         2: gen = {BBX_OP_SKIPLO, r[9:0]};
         3: gen = {BBX_OP_SKIPHI, r[9:0]};
         4: gen = {BBX_OP_RJMP, r[8:0]};
         5: gen = BBX_JW_WORD;
         6: gen = {BBX_OP_CALL, r[10:0]};
         7: gen = BBX_CW_WORD;
         8: gen = BBX_WDT_WORD;
         9: gen = {BBX_OP_INV, r[7:0]};
         10: gen = {BBX_OP_ZREG, r[6:0]};
         11: gen = {BBX_OP_DEC, r[7:0]};
         default: gen = BBX_ZW_WORD;
      endcase
   endfunction : gen

   // Drive one cycle at the edge and work out what the core must answer
   task automatic exec(input logic [13:0] ins, input logic v, input logic [7:0] fd);
      logic [7:0] ac;
      logic [7:0] res;
      logic [6:0] la;
      logic [2:0] b;
      logic rt;
      ac = 8'($urandom);
      la = 7'($urandom);
      b = ins[9:7];
      rt = 1'b0;
      res = 8'h00;
      i_valid <= v;
      i_instr <= ins;
      i_file_rdata <= fd;
      i_acc <= ac;
      i_pc_upper_latch <= la;
      x = e;
      {x.fwe, x.awe, x.zwe, x.psh, x.fls, x.wdc} = 6'h00;
      x.pc = e.pc + 15'(v);
      x.fa = ins[6:0];
      if (v && !m_kill) begin
         casez (ins)
            14'b0100??????????: {x.fwe, x.fd} = {1'b1, fd & ~(8'h01 << b)};
            14'b0101??????????: {x.fwe, x.fd} = {1'b1, fd | (8'h01 << b)};
            14'b0110??????????: x.fls = ~fd[b];
            14'b0111??????????: x.fls = fd[b];
            14'b11001?????????: begin
               x.pc = e.pc + 15'h0001 + {{6{ins[8]}}, ins[8:0]};
               x.fls = 1'b1;
            end
            BBX_JW_WORD: begin
               x.pc = e.pc + 15'h0001 + {7'h00, ac};
               x.fls = 1'b1;
            end
            14'b100???????????: begin
               {x.psh, x.fls, x.stk} = {2'b11, e.pc + 15'h0001};
               x.pc = {la[6:3], ins[10:0]};
            end
            BBX_CW_WORD: begin
               {x.psh, x.fls, x.stk} = {2'b11, e.pc + 15'h0001};
               x.pc = {la, ac};
            end
            BBX_WDT_WORD: x.wdc = 1'b1;
            14'b001001????????: {rt, res} = {1'b1, ~fd};
            14'b0000011???????: {x.fwe, x.fd, x.zwe, x.z} = {1'b1, 8'h00, 2'b11};
            14'b000011????????: {rt, res} = {1'b1, fd - 8'h01};
            BBX_ZW_WORD: {x.awe, x.ad, x.zwe, x.z} = {1'b1, 8'h00, 2'b11};
            default: ;
         endcase
      end
      // Destination bit routes the result, zero flag follows it
      if (rt) begin
         {x.zwe, x.z} = {1'b1, res == 8'h00};
         if (ins[BBX_DEST_BIT]) {x.fwe, x.fd} = {1'b1, res};
         else {x.awe, x.ad} = {1'b1, res};
      end
      // An idle cycle leaves a pending discard in place
      if (v) m_kill = x.fls;
      @(posedge i_clk);
      e = x;
      chk_on = 1'b1;
   endtask : exec

   // Compare every output half a cycle after the edge that launched it
   always @(negedge i_clk) begin
      if (chk_on) begin
         chk(16'(o_file_we), 16'(e.fwe));
         chk(16'(o_file_addr), 16'(e.fa));
         chk(16'(o_file_wdata), 16'(e.fd));
         chk(16'(o_acc_we), 16'(e.awe));
         chk(16'(o_acc_wdata), 16'(e.ad));
         chk(16'(o_zero_we), 16'(e.zwe));
         chk(16'(o_result_null_flag), 16'(e.z));
         chk(16'(o_pc), 16'(e.pc));
         chk(16'(o_push), 16'(e.psh));
         chk(16'(o_stack_top), 16'(e.stk));
         chk(16'(o_flush), 16'(e.fls));
         chk(16'(o_wdt_clear), 16'(e.wdc));
         chk(16'(o_timeout_flag_n), 16'h0001);
         chk(16'(o_sleep_flag_n), 16'h0001);
      end
   end

   // Directed boundaries, random stream, mid-run reset, directed again
   initial begin
      void'($urandom(32'h374bbc6c));
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         exec(DIR[i], 1'b1, DFD[i]);
      end
      $display("directed test done, checks %0d", n_tests);
      for (int i = 0; i < 2000; i++) begin
         exec(gen($urandom_range(12)), 1'($urandom_range(3) != 0), 8'($urandom));
      end
      $display("random test done, checks %0d", n_tests);
      // Idle cycle first, so the last random result is still compared
      exec(BBX_NOP_WORD, 1'b0, 8'h00);
      i_nrst <= 1'b0;
      e = '0;
      m_kill = 1'b0;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         exec(DIR[i], 1'b1, DFD[i]);
      end
      exec(BBX_NOP_WORD, 1'b0, 8'h00);
      $display("reset test done, checks %0d", n_tests);
      test_done();
   end

   // Watchdog: the whole run needs about 2050 cycles
   initial begin
      #150000;
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
